// >>> src/tcs_config_status.sv
// Contract
// - Match flag is set when configuration equals the stored non-volatile image.
// - Uncorrectable flag is set when a word holds a double-bit error.
// - Single-bit errors are corrected and reported by their own flag.
// - Shorted temperature sensor sets a status flag.
// - Open temperature sensor sets a status flag.
// - Long mode sets precounter overflow flag when the coarse range runs out.
// - Fine unit overflow sets a timeout flag.
// - Store command copies configuration into non-volatile memory.
// - Restore command loads configuration from non-volatile memory.
// - Compare command reports whether configuration and memory match.
// - Short mode measures intervals from 3.5 ns up to microseconds; the code's lower bound is one 40 ns clock cycle.
// - Long mode measures 500 ns to 4 ms between start and stop.
// - Enabled fire generator emits 10 pulses at 1 MHz per sequence.
// - Stop hits are ignored until the stop window delay elapses.
// - Opcode 0x50 resets everything except the non-volatile image, configuration included.
// - Opcode 0x70 prepares a measurement and keeps configuration.
// - Non-volatile memory holds seven 32-bit words including a user identifier.
`timescale 1ns/1ns
`default_nettype none

module tcs_config_status #(
  parameter longint LongMaxCycles = tcs_pkg::LONG_MAX_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic startHit,
  input wire logic stopHit,
  input wire logic tempShortDet,
  input wire logic tempOpenDet,
  output logic fireOut
);

  // ==========================================================================
  // Error correction
  // ==========================================================================
  // Hamming code over positions 1..38 with overall parity at position 0.
  function automatic logic [38:0] eccEncode(input logic [31:0] d);
    logic [38:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p < tcs_pkg::ECC_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[k];
        k++;
      end
    end
    for (int b = 0; b < 6; b++) begin
      for (int p = 1; p < tcs_pkg::ECC_BITS; p++) begin
        if (((p >> b) & 1) == 1) begin
          c[1 << b] = c[1 << b] ^ c[p];
        end
      end
    end
    c[0] = ^c[38:1];
    return c;
  endfunction : eccEncode

  function automatic tcs_pkg::tcs_ecc_s eccDecode(input logic [38:0] cIn);
    logic [38:0] c;
    logic [5:0] s;
    logic overall;
    int k;
    tcs_pkg::tcs_ecc_s r;
    c = cIn;
    s = '0;
    k = 0;
    r = '0;
    for (int p = 1; p < tcs_pkg::ECC_BITS; p++) begin
      if (c[p]) begin
        s = s ^ 6'(p);
      end
    end
    overall = ^c;
    if (overall) begin
      r.single = 1'b1;
      if (s < 6'(tcs_pkg::ECC_BITS)) begin
        c[s] = ~c[s];
      end else begin
        r.double = 1'b1;
      end
    end else if (s != 6'h00) begin
      r.double = 1'b1;
    end
    for (int p = 1; p < tcs_pkg::ECC_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        r.data[k] = c[p];
        k++;
      end
    end
    return r;
  endfunction : eccDecode

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic [1:0] rstSync;
  logic rstN;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic [31:0] cfgWord [tcs_pkg::NVM_WORDS];
  logic [38:0] nvmCode [tcs_pkg::NVM_WORDS];
  tcs_pkg::tcs_status_s status;
  tcs_pkg::tcs_nvm_e nvmOp;
  tcs_pkg::tcs_meas_e meas;
  logic [2:0] nvmIdx;
  logic nvmMismatch;
  logic nvmSeenSingle;
  logic nvmSeenDouble;
  logic [tcs_pkg::ELAPSED_BITS-1:0] elapsed;
  logic [31:0] result;
  logic apbDone;
  logic wrDone;
  logic isCfg;
  logic addrOk;
  logic refused;
  logic [31:0] readData;
  logic cmdFullReset;
  logic cmdInit;
  logic cmdStore;
  logic cmdRestore;
  logic cmdCompare;
  logic faultWrite;
  logic cfgWrite;
  logic [2:0] wordSel;
  logic nvmBusy;

  assign apbDone = psel & penable & pready;
  assign nvmBusy = (nvmOp != tcs_pkg::NVM_IDLE);
  assign wordSel = paddr[4:2];
  assign isCfg = (paddr[1:0] == 2'h0) && (paddr <= tcs_pkg::OFS_USER_ID);

  always_comb begin
    addrOk = 1'b1;
    readData = 32'h0000_0000;
    refused = 1'b0;
    if (isCfg) begin
      readData = cfgWord[wordSel];
      refused = pwrite & nvmBusy;
    end else begin
      unique case (paddr)
        tcs_pkg::OFS_COMMAND: refused = pwrite & nvmBusy;
        tcs_pkg::OFS_STATUS: begin
          readData = 32'(status);
          refused = pwrite;
        end
        tcs_pkg::OFS_RESULT: begin
          readData = result;
          refused = pwrite;
        end
        tcs_pkg::OFS_NVM_FAULT: refused = pwrite & nvmBusy;
        default: addrOk = 1'b0;
      endcase
    end
  end

  assign wrDone = apbDone & pwrite & addrOk & ~refused;
  assign cfgWrite = wrDone & isCfg;
  assign faultWrite = wrDone & (paddr == tcs_pkg::OFS_NVM_FAULT);
  assign cmdFullReset = wrDone & (paddr == tcs_pkg::OFS_COMMAND) && (pwdata[7:0] == tcs_pkg::OP_FULL_RESET);
  assign cmdInit = wrDone & (paddr == tcs_pkg::OFS_COMMAND) && (pwdata[7:0] == tcs_pkg::OP_INIT);
  assign cmdStore = wrDone & (paddr == tcs_pkg::OFS_COMMAND) && (pwdata[7:0] == tcs_pkg::OP_NVM_STORE);
  assign cmdRestore = wrDone & (paddr == tcs_pkg::OFS_COMMAND) && (pwdata[7:0] == tcs_pkg::OP_NVM_RESTORE);
  assign cmdCompare = wrDone & (paddr == tcs_pkg::OFS_COMMAND) && (pwdata[7:0] == tcs_pkg::OP_NVM_COMPARE);

  // Every transfer answers after one wait state; read data is captured with pready.
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clkEn) begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (~addrOk | refused);
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= readData;
      end
    end
  end

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  tcs_pkg::tcs_ecc_s nvmRead;
  assign nvmRead = eccDecode(nvmCode[nvmIdx]);

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < tcs_pkg::NVM_WORDS; i++) begin
        cfgWord[i] <= tcs_pkg::CONFIG_RESET;
      end
    end else if (clkEn) begin
      if (cmdFullReset) begin
        for (int i = 0; i < tcs_pkg::NVM_WORDS; i++) begin
          cfgWord[i] <= tcs_pkg::CONFIG_RESET;
        end
      end else if (cfgWrite) begin
        cfgWord[wordSel] <= pwdata;
      end else if (nvmOp == tcs_pkg::NVM_RESTORE) begin
        cfgWord[nvmIdx] <= nvmRead.data;
      end
    end
  end

  // ==========================================================================
  // Non-volatile image
  // ==========================================================================
  // The image survives a full reset; only the pin reset clears it, and the all-zero
  // codeword is itself a valid encoding of zero.
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < tcs_pkg::NVM_WORDS; i++) begin
        nvmCode[i] <= 39'h00_0000_0000;
      end
    end else if (clkEn) begin
      if (nvmOp == tcs_pkg::NVM_STORE) begin
        nvmCode[nvmIdx] <= eccEncode(cfgWord[nvmIdx]);
      end else if (faultWrite && (pwdata[10:8] < 3'(tcs_pkg::NVM_WORDS)) && (pwdata[5:0] < 6'(tcs_pkg::ECC_BITS))) begin
        nvmCode[pwdata[tcs_pkg::FAULT_WORD_LSB +: 3]][pwdata[tcs_pkg::FAULT_POS_LSB +: 6]] <=
          ~nvmCode[pwdata[tcs_pkg::FAULT_WORD_LSB +: 3]][pwdata[tcs_pkg::FAULT_POS_LSB +: 6]];
      end
    end
  end

  // One word per cycle; a command write, full reset included, is refused while an operation runs.
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      nvmOp <= tcs_pkg::NVM_IDLE;
      nvmIdx <= 3'h0;
      nvmMismatch <= 1'b0;
      nvmSeenSingle <= 1'b0;
      nvmSeenDouble <= 1'b0;
    end else if (clkEn) begin
      if (cmdFullReset) begin
        nvmOp <= tcs_pkg::NVM_IDLE;
      end else if (!nvmBusy) begin
        nvmIdx <= 3'h0;
        nvmMismatch <= 1'b0;
        nvmSeenSingle <= 1'b0;
        nvmSeenDouble <= 1'b0;
        if (cmdStore) begin
          nvmOp <= tcs_pkg::NVM_STORE;
        end else if (cmdRestore) begin
          nvmOp <= tcs_pkg::NVM_RESTORE;
        end else if (cmdCompare) begin
          nvmOp <= tcs_pkg::NVM_COMPARE;
        end
      end else begin
        nvmMismatch <= nvmMismatch | (nvmRead.data != cfgWord[nvmIdx]);
        nvmSeenSingle <= nvmSeenSingle | (nvmRead.single & ~nvmRead.double);
        nvmSeenDouble <= nvmSeenDouble | nvmRead.double;
        nvmIdx <= nvmIdx + 3'h1;
        if (nvmIdx == 3'(tcs_pkg::NVM_WORDS - 1)) begin
          nvmOp <= tcs_pkg::NVM_IDLE;
          nvmIdx <= 3'h0;
        end
      end
    end
  end

  // ==========================================================================
  // Status flags
  // ==========================================================================
  logic nvmLast;
  logic timeout;
  logic stopOk;
  logic longMode;
  logic [tcs_pkg::ELAPSED_BITS-1:0] minCycles;
  logic [tcs_pkg::ELAPSED_BITS-1:0] maxCycles;

  assign nvmLast = nvmBusy && (nvmIdx == 3'(tcs_pkg::NVM_WORDS - 1));
  assign longMode = cfgWord[0][tcs_pkg::CFG_LONG_MODE_BIT];
  assign minCycles = longMode ? tcs_pkg::ELAPSED_BITS'(tcs_pkg::LONG_MIN_CYCLES) :
    tcs_pkg::ELAPSED_BITS'(tcs_pkg::SHORT_MIN_CYCLES);
  assign maxCycles = longMode ? tcs_pkg::ELAPSED_BITS'(LongMaxCycles) :
    tcs_pkg::ELAPSED_BITS'(tcs_pkg::SHORT_MAX_CYCLES);
  assign timeout = (meas == tcs_pkg::MEAS_RUN) && (elapsed >= maxCycles);
  assign stopOk = (meas == tcs_pkg::MEAS_RUN) && stopHit && !timeout && (elapsed >= minCycles) &&
    (elapsed >= tcs_pkg::ELAPSED_BITS'(cfgWord[tcs_pkg::CFG_DELAY_WORD][tcs_pkg::CFG_DELAY_LSB +: tcs_pkg::CFG_DELAY_BITS]));

  // Sticky bits: an event in the cycle of init or full reset still sets its flag.
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      status <= '0;
    end else if (clkEn) begin
      if (cmdFullReset | cmdInit) begin
        status.nvmCorrected <= 1'b0;
        status.nvmUncorrectable <= 1'b0;
        status.tempShort <= 1'b0;
        status.tempOpen <= 1'b0;
        status.precountOvf <= 1'b0;
        status.fineOvf <= 1'b0;
        status.measDone <= 1'b0;
      end
      if (tempShortDet) status.tempShort <= 1'b1;
      if (tempOpenDet) status.tempOpen <= 1'b1;
      if (timeout & longMode) status.precountOvf <= 1'b1;
      if (timeout & ~longMode) status.fineOvf <= 1'b1;
      if (stopOk | timeout) status.measDone <= 1'b1;
      status.nvmBusy <= nvmBusy & ~nvmLast & ~cmdFullReset;
      if (!nvmBusy & (cmdStore | cmdRestore | cmdCompare) & !cmdFullReset) status.nvmBusy <= 1'b1;
      if (nvmLast & !cmdFullReset & (nvmOp != tcs_pkg::NVM_STORE)) begin
        if (nvmSeenSingle | (nvmRead.single & ~nvmRead.double)) status.nvmCorrected <= 1'b1;
        if (nvmSeenDouble | nvmRead.double) status.nvmUncorrectable <= 1'b1;
      end
      // A configuration change breaks the match until the next store, restore or compare.
      if (cmdFullReset | cfgWrite) begin
        status.nvmMatch <= 1'b0;
      end else if (nvmLast) begin
        unique case (nvmOp)
          tcs_pkg::NVM_STORE: status.nvmMatch <= 1'b1;
          tcs_pkg::NVM_RESTORE: status.nvmMatch <= ~(nvmSeenDouble | nvmRead.double);
          default: status.nvmMatch <= ~(nvmMismatch | (nvmRead.data != cfgWord[nvmIdx]));
        endcase
      end
    end
  end

  // ==========================================================================
  // Measurement
  // ==========================================================================
  // Resolution is one clock cycle; the sub-cycle lower bound rounds up to one cycle.
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      meas <= tcs_pkg::MEAS_IDLE;
      elapsed <= '0;
      result <= 32'h0000_0000;
    end else if (clkEn) begin
      if (cmdFullReset) begin
        meas <= tcs_pkg::MEAS_IDLE;
        result <= 32'h0000_0000;
      end else if (cmdInit) begin
        meas <= tcs_pkg::MEAS_ARMED;
        result <= 32'h0000_0000;
      end else begin
        unique case (meas)
          tcs_pkg::MEAS_IDLE, tcs_pkg::MEAS_DONE: meas <= meas;
          tcs_pkg::MEAS_ARMED: begin
            elapsed <= '0;
            if (startHit) meas <= tcs_pkg::MEAS_RUN;
          end
          tcs_pkg::MEAS_RUN: begin
            elapsed <= elapsed + 1'b1;
            if (stopOk) begin
              result <= 32'(elapsed);
              meas <= tcs_pkg::MEAS_DONE;
            end else if (timeout) begin
              meas <= tcs_pkg::MEAS_DONE;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Fire burst
  // ==========================================================================
  logic [4:0] firePhase;
  logic [3:0] firePulses;
  logic fireActive;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      fireActive <= 1'b0;
      firePhase <= 5'h00;
      firePulses <= 4'h0;
      fireOut <= 1'b0;
    end else if (clkEn) begin
      if (cmdFullReset | cmdInit) begin
        fireActive <= 1'b0;
        fireOut <= 1'b0;
      end else if (meas == tcs_pkg::MEAS_ARMED && startHit && cfgWord[0][tcs_pkg::CFG_FIRE_EN_BIT]) begin
        fireActive <= 1'b1;
        firePhase <= 5'h00;
        firePulses <= 4'h0;
        fireOut <= 1'b0;
      end else if (fireActive) begin
        fireOut <= (firePhase < 5'(tcs_pkg::FIRE_PERIOD_CYCLES / 2));
        if (firePhase == 5'(tcs_pkg::FIRE_PERIOD_CYCLES - 1)) begin
          firePhase <= 5'h00;
          firePulses <= firePulses + 4'h1;
          if (firePulses == 4'(tcs_pkg::FIRE_PULSES - 1)) fireActive <= 1'b0;
        end else begin
          firePhase <= firePhase + 5'h01;
        end
      end else begin
        fireOut <= 1'b0;
      end
    end
  end

endmodule : tcs_config_status

`default_nettype wire

// >>> src/tcs_pkg.sv
package tcs_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLOCK_PERIOD_PS = 40000;
  localparam int SHORT_MIN_PS = 3500;
  localparam int SHORT_MAX_NS = 2500;
  localparam int LONG_MIN_NS = 500;
  localparam int LONG_MAX_NS = 4000000;
  localparam int FIRE_PERIOD_NS = 1000;
  localparam int FIRE_PULSES = 10;
  localparam int SHORT_MIN_RAW = (SHORT_MIN_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int SHORT_MIN_CYCLES = (SHORT_MIN_RAW < 1) ? 1 : SHORT_MIN_RAW;
  localparam int SHORT_MAX_CYCLES = (SHORT_MAX_NS * 1000) / CLOCK_PERIOD_PS;
  localparam int LONG_MIN_CYCLES = (LONG_MIN_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam longint LONG_MAX_CYCLES = (longint'(LONG_MAX_NS) * 1000) / CLOCK_PERIOD_PS;
  localparam int FIRE_PERIOD_CYCLES = (FIRE_PERIOD_NS * 1000) / CLOCK_PERIOD_PS;
  localparam int PRECOUNT_BITS = 14;
  localparam int ELAPSED_BITS = 17;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] OFS_CONFIG0 = 8'h00;
  localparam logic [7:0] OFS_USER_ID = 8'h18;
  localparam logic [7:0] OFS_COMMAND = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_RESULT = 8'h24;
  localparam logic [7:0] OFS_NVM_FAULT = 8'h28;
  localparam int NVM_WORDS = 7;
  localparam int USER_ID_INDEX = 6;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

  // ==========================================================================
  // Fields and opcodes
  // ==========================================================================
  localparam int CFG_LONG_MODE_BIT = 0;
  localparam int CFG_FIRE_EN_BIT = 1;
  localparam int CFG_DELAY_WORD = 1;
  localparam int CFG_DELAY_LSB = 0;
  localparam int CFG_DELAY_BITS = 16;
  localparam int FAULT_POS_LSB = 0;
  localparam int FAULT_WORD_LSB = 8;
  localparam logic [7:0] OP_FULL_RESET = 8'h50;
  localparam logic [7:0] OP_INIT = 8'h70;
  localparam logic [7:0] OP_NVM_STORE = 8'hE1;
  localparam logic [7:0] OP_NVM_RESTORE = 8'hE2;
  localparam logic [7:0] OP_NVM_COMPARE = 8'hE3;
  localparam int ECC_BITS = 39;

  typedef enum {MEAS_IDLE, MEAS_ARMED, MEAS_RUN, MEAS_DONE} tcs_meas_e;
  typedef enum {NVM_IDLE, NVM_STORE, NVM_RESTORE, NVM_COMPARE} tcs_nvm_e;

  // Bit 0 is nvmMatch, bit 8 is measDone.
  typedef struct packed {
    logic measDone;
    logic nvmBusy;
    logic fineOvf;
    logic precountOvf;
    logic tempOpen;
    logic tempShort;
    logic nvmUncorrectable;
    logic nvmCorrected;
    logic nvmMatch;
  } tcs_status_s;

  typedef struct packed {
    logic [31:0] data;
    logic single;
    logic double;
  } tcs_ecc_s;

endpackage : tcs_pkg

// >>> verif/tcs_config_status_props.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Port checker
// ==========================================================================
module tcs_config_status_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tempShortDet,
  input wire logic tempOpenDet,
  input wire logic fireOut
);
  logic shortSeen, shortSeenQ, openSeen, openSeenQ, flagClear, statusRead;
  assign flagClear = psel && penable && pready && pwrite && paddr == tcs_pkg::OFS_COMMAND &&
    (pwdata[7:0] == tcs_pkg::OP_FULL_RESET || pwdata[7:0] == tcs_pkg::OP_INIT);
  assign statusRead = pready && !pwrite && paddr == tcs_pkg::OFS_STATUS;
  // The extra stage covers the registered read data, which lags a fault by one edge.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shortSeen <= 1'b0;
      openSeen <= 1'b0;
      shortSeenQ <= 1'b0;
      openSeenQ <= 1'b0;
    end else begin
      shortSeen <= tempShortDet || (shortSeen && !flagClear);
      openSeen <= tempOpenDet || (openSeen && !flagClear);
      shortSeenQ <= shortSeen;
      openSeenQ <= openSeen;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_readyPulse; pready |=> !pready; endproperty
  a_readyPulse: assert property (p_readyPulse) else $error("pready held too long");
  property p_readyAnswer; psel && penable && !$past(penable) |=> pready; endproperty
  a_readyAnswer: assert property (p_readyAnswer) else $error("pready late");
  property p_errWithReady; pslverr |-> pready; endproperty
  a_errWithReady: assert property (p_errWithReady) else $error("pslverr without pready");
  property p_readHold; !pready |-> $stable(prdata); endproperty
  a_readHold: assert property (p_readHold) else $error("prdata moved between reads");
  property p_unmapped;
    pready && (paddr > tcs_pkg::OFS_NVM_FAULT || paddr[1:0] != 2'h0) |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  property p_readOnly;
    pready && pwrite && (paddr == tcs_pkg::OFS_STATUS || paddr == tcs_pkg::OFS_RESULT) |-> pslverr;
  endproperty
  a_readOnly: assert property (p_readOnly) else $error("read-only write accepted");
  property p_fireHigh; $rose(fireOut) |-> fireOut[*8] ##1 fireOut[*4] ##1 !fireOut; endproperty
  a_fireHigh: assert property (p_fireHigh) else $error("fire pulse width wrong");
  property p_fireLow; $fell(fireOut) |-> !fireOut[*8] ##1 !fireOut[*5]; endproperty
  a_fireLow: assert property (p_fireLow) else $error("fire gap too short");
  property p_tempShort; statusRead && shortSeenQ |-> prdata[3]; endproperty
  a_tempShort: assert property (p_tempShort) else $error("short flag missing");
  property p_tempOpen; statusRead && openSeenQ |-> prdata[4]; endproperty
  a_tempOpen: assert property (p_tempOpen) else $error("open flag missing");
  c_err: cover property (pslverr);
  c_fire: cover property ($fell(fireOut));
  c_fault: cover property (statusRead && shortSeenQ);
endmodule : tcs_config_status_props

bind tcs_config_status tcs_config_status_props tcs_config_status_props_inst (.clock(clock), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tempShortDet(tempShortDet), .tempOpenDet(tempOpenDet), .fireOut(fireOut));
`default_nettype wire

// >>> verif/tcs_config_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tcs_config_status_tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic startHit = 1'b0;
  logic stopHit = 1'b0;
  logic tempShortDet = 1'b0;
  logic tempOpenDet = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, fireOut, timedOut, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int failCount = 0;
  int nTests = 0;
  int fires = 0;
  always #20 clock = ~clock;
  always @(posedge fireOut) fires++;
  tcs_config_status #(.LongMaxCycles(300)) tcs_config_status_inst (.clock(clock), .rst_b(rst_b), .clkEn(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .startHit(startHit), .stopHit(stopHit), .tempShortDet(tempShortDet),
    .tempOpenDet(tempOpenDet), .fireOut(fireOut));
  tcs_host_model tcs_host_model_inst (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timedOut(timedOut));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic closeOut();
    $display("comparisons %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : closeOut
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tcs_host_model_inst.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdw(input logic [7:0] a);
    tcs_host_model_inst.xfer(1'b0, a, 32'h0, rd, err);
  endtask : rdw
  // Leaves the last status word in rd once the store engine is idle.
  task automatic cmd(input logic [7:0] op);
    int n;
    wr(tcs_pkg::OFS_COMMAND, {24'h0, op});
    n = 0;
    do begin
      rdw(tcs_pkg::OFS_STATUS);
      n++;
    end while (rd[7] !== 1'b0 && n < 30);
    if (n >= 30) begin
      failCount++;
      closeOut();
    end
  endtask : cmd
  task automatic run(input int gap, input int rest);
    startHit <= 1'b1;
    @(posedge clock);
    startHit <= 1'b0;
    repeat (3) @(posedge clock);
    stopHit <= 1'b1;
    @(posedge clock);
    stopHit <= 1'b0;
    if (gap > 0) begin
      repeat (gap) @(posedge clock);
      stopHit <= 1'b1;
      @(posedge clock);
      stopHit <= 1'b0;
    end
    repeat (rest) @(posedge clock);
    rdw(tcs_pkg::OFS_STATUS);
  endtask : run
  function automatic logic [31:0] pat(input int i);
    return {16'hC0DE, 8'(i), 8'h00};
  endfunction : pat
  always @(posedge timedOut) begin
    failCount++;
    closeOut();
  end
  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    wr(tcs_pkg::OFS_CONFIG0, 32'h0000_00A5);
    cmd(tcs_pkg::OP_FULL_RESET);
    rdw(tcs_pkg::OFS_CONFIG0);
    chk(rd, 32'h0);
    for (int i = 0; i < 7; i++) wr(8'(i * 4), pat(i));
    for (int i = 0; i < 7; i++) begin
      rdw(8'(i * 4));
      chk(rd, pat(i));
    end
    rdw(8'h2C);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    wr(tcs_pkg::OFS_STATUS, 32'h1);
    chk(err, 1'b1);
    $display("test map done");
    cmd(tcs_pkg::OP_NVM_STORE);
    chk(rd[0], 1'b1);
    wr(8'h08, 32'h0);
    rdw(tcs_pkg::OFS_STATUS);
    chk(rd[0], 1'b0);
    cmd(tcs_pkg::OP_NVM_COMPARE);
    chk(rd[0], 1'b0);
    cmd(tcs_pkg::OP_NVM_RESTORE);
    chk(rd[0], 1'b1);
    rdw(8'h08);
    chk(rd, pat(2));
    wr(8'h08, pat(2));
    cmd(tcs_pkg::OP_NVM_COMPARE);
    chk(rd[0], 1'b1);
    wr(tcs_pkg::OFS_NVM_FAULT, {21'h0, 3'h2, 2'h0, 6'h05});
    cmd(tcs_pkg::OP_NVM_RESTORE);
    chk(rd[2:1], 2'h1);
    rdw(8'h08);
    chk(rd, pat(2));
    wr(tcs_pkg::OFS_NVM_FAULT, {21'h0, 3'h2, 2'h0, 6'h09});
    cmd(tcs_pkg::OP_NVM_RESTORE);
    chk(rd[2], 1'b1);
    cmd(tcs_pkg::OP_INIT);
    chk(rd[2:1], 2'h0);
    $display("test store done");
    tempShortDet <= 1'b1;
    tempOpenDet <= 1'b1;
    @(posedge clock);
    tempShortDet <= 1'b0;
    tempOpenDet <= 1'b0;
    rdw(tcs_pkg::OFS_STATUS);
    chk(rd[4:3], 2'h3);
    cmd(tcs_pkg::OP_INIT);
    chk(rd[4:3], 2'h0);
    $display("test sensor done");
    wr(8'h04, 32'h14);
    wr(tcs_pkg::OFS_CONFIG0, 32'h0);
    cmd(tcs_pkg::OP_INIT);
    rdw(8'h04);
    chk(rd, 32'h14);
    run(25, 5);
    chk(rd[8], 1'b1);
    rdw(tcs_pkg::OFS_RESULT);
    chk(rd >= 32'h14 && rd < 32'h28, 1'b1);
    cmd(tcs_pkg::OP_INIT);
    run(0, 70);
    chk(rd[6:5], 2'h2);
    wr(tcs_pkg::OFS_CONFIG0, 32'h1);
    wr(8'h04, 32'h0);
    cmd(tcs_pkg::OP_INIT);
    run(25, 5);
    rdw(tcs_pkg::OFS_RESULT);
    chk(rd >= 32'h0D && rd < 32'h28, 1'b1);
    wr(tcs_pkg::OFS_CONFIG0, 32'h3);
    cmd(tcs_pkg::OP_INIT);
    fires = 0;
    run(0, 320);
    chk(rd[6:5], 2'h1);
    chk(fires, 32'hA);
    $display("test measure done");
    closeOut();
  end
endmodule : tcs_config_status_tb
`default_nettype wire

// >>> verif/tcs_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Host bus master
// ==========================================================================
module tcs_host_model (
  input wire logic clock,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [7:0] paddr,
  output var logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output var logic timedOut
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    timedOut = 1'b0;
  end
  // Status and data reach the host only through these transfers.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timedOut <= 1'b1;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : tcs_host_model
`default_nettype wire
